// ### verilog/ecmd_pkg.sv
package ecmd_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DUTY_HI = 8'h04;
  localparam logic [7:0] OFS_CMP_HI = 8'h08;
  localparam logic [7:0] OFS_CAPT = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_STEER = 8'h14;
  localparam logic [7:0] OFS_DBAND = 8'h18;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] STEER_RST = 4'h1;
  localparam logic [6:0] DBAND_RST = 7'h00;

  // field positions
  localparam int STAT_FLAG_BIT = 0;

  // capture prescale terminal counts
  localparam logic [3:0] PRESC4_LAST = 4'h3;
  localparam logic [3:0] PRESC16_LAST = 4'hf;

  // output configurations
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_REV = 2'h3;

  typedef enum logic [3:0] {
    M_OFF = 4'b0000,
    M_RSV1 = 4'b0001,
    M_CMP_TGL = 4'b0010,
    M_RSV3 = 4'b0011,
    M_CAP_FALL = 4'b0100,
    M_CAP_RISE = 4'b0101,
    M_CAP_4 = 4'b0110,
    M_CAP_16 = 4'b0111,
    M_CMP_SET = 4'b1000,
    M_CMP_CLR = 4'b1001,
    M_CMP_SWI = 4'b1010,
    M_CMP_TRIG = 4'b1011,
    M_PWM_HH = 4'b1100,
    M_PWM_HL = 4'b1101,
    M_PWM_LH = 4'b1110,
    M_PWM_LL = 4'b1111
  } ecmd_mode_t;

  typedef struct packed {
    logic [1:0] output_configuration_field;
    logic [1:0] duty_low_bits;
    ecmd_mode_t unit_mode_field;
  } ecmd_ctrl_t;

  typedef struct packed {
    logic [3:0] drv;
    logic [3:0] oe_n;
  } ecmd_pins_t;

endpackage

// ### verilog/ecmd_top.sv
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
module ecmd_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timebases
  input wire logic [15:0] tmr_value,
  input wire logic [9:0] pwm_count,
  input wire logic pwm_period_start,
  // pins and events
  input wire logic cap_pin_in,
  output ecmd_pkg::ecmd_pins_t pin_q,
  output logic tmr_reset,
  output logic adc_start,
  output logic unit_interrupt_flag
);

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = (m[3:2] == 2'b11);
  endfunction

  function automatic logic is_cmp(input logic [3:0] m);
    is_cmp = (m[3:2] == 2'b10) || (m == 4'b0010);
  endfunction

  ecmd_pkg::ecmd_ctrl_t ctrl_q;
  logic [7:0] duty_hi_q, cmp_hi_q;
  logic [15:0] capt_q;
  logic flag_q;
  logic [3:0] steer_q;
  logic [6:0] dband_q, db_cnt_q;
  logic [3:0] presc_q;
  logic cap_prev_q, match_prev_q, cmp_out_q, run_q, raw_prev_q;
  logic [9:0] duty_sh_q;
  logic tmr_reset_q, adc_start_q, pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0] mode;
  logic acc, wr, cap_ev, cmp_ev, raw, db_idle;
  logic [3:0] act, oe_n, pol, drv;

  assign mode = ctrl_q.unit_mode_field;
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tmr_reset = tmr_reset_q;
  assign adc_start = adc_start_q;
  assign unit_interrupt_flag = flag_q;

  // apb handshake, one access cycle, error on unmapped address
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      if (psel & ~penable) begin
        unique case (paddr)
          ecmd_pkg::OFS_CTRL: prdata_q <= {24'h0, ctrl_q};
          ecmd_pkg::OFS_DUTY_HI: prdata_q <= {24'h0, duty_hi_q};
          ecmd_pkg::OFS_CMP_HI: prdata_q <= {24'h0, cmp_hi_q};
          ecmd_pkg::OFS_CAPT: prdata_q <= {16'h0, capt_q};
          ecmd_pkg::OFS_STAT: prdata_q <= {31'h0, flag_q};
          ecmd_pkg::OFS_STEER: prdata_q <= {28'h0, steer_q};
          ecmd_pkg::OFS_DBAND: prdata_q <= {25'h0, dband_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= ecmd_pkg::CTRL_RST;
      duty_hi_q <= 8'h00;
      cmp_hi_q <= 8'h00;
      steer_q <= ecmd_pkg::STEER_RST;
      dband_q <= ecmd_pkg::DBAND_RST;
    end else if (wr) begin
      unique case (paddr)
        ecmd_pkg::OFS_CTRL: ctrl_q <= pwdata[7:0];
        ecmd_pkg::OFS_DUTY_HI: duty_hi_q <= pwdata[7:0];
        ecmd_pkg::OFS_CMP_HI: cmp_hi_q <= pwdata[7:0];
        ecmd_pkg::OFS_STEER: steer_q <= pwdata[3:0];
        ecmd_pkg::OFS_DBAND: dband_q <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // capture edge detect and prescale
  always_comb begin
    cap_ev = 1'b0;
    unique case (mode)
      ecmd_pkg::M_CAP_FALL: cap_ev = cap_prev_q & ~cap_pin_in;
      ecmd_pkg::M_CAP_RISE: cap_ev = ~cap_prev_q & cap_pin_in;
      ecmd_pkg::M_CAP_4: cap_ev = ~cap_prev_q & cap_pin_in &
        (presc_q == ecmd_pkg::PRESC4_LAST);
      ecmd_pkg::M_CAP_16: cap_ev = ~cap_prev_q & cap_pin_in &
        (presc_q == ecmd_pkg::PRESC16_LAST);
      default: cap_ev = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cap_prev_q <= 1'b0;
      presc_q <= 4'h0;
    end else begin
      cap_prev_q <= cap_pin_in;
      if (mode[3:1] != 3'b011) begin
        presc_q <= 4'h0;
      end else if (~cap_prev_q & cap_pin_in) begin
        presc_q <= cap_ev ? 4'h0 : presc_q + 4'h1;
      end
    end
  end

  // capture register overwritten by every capture
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      capt_q <= 16'h0;
    end else if (cap_ev) begin
      capt_q <= tmr_value;
    end
  end

  // compare match, one event per match
  assign cmp_ev = is_cmp(mode) & ~match_prev_q &
    (tmr_value == {cmp_hi_q, duty_hi_q});

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      match_prev_q <= 1'b0;
      cmp_out_q <= 1'b0;
    end else begin
      match_prev_q <= is_cmp(mode) & (tmr_value == {cmp_hi_q, duty_hi_q});
      if (wr && paddr == ecmd_pkg::OFS_CTRL) begin
        unique case (pwdata[3:0])
          4'b1000: cmp_out_q <= 1'b0;
          4'b1001: cmp_out_q <= 1'b1;
          4'b0000: cmp_out_q <= 1'b0;
          default: ;
        endcase
      end else if (mode == ecmd_pkg::M_OFF) begin
        cmp_out_q <= 1'b0;
      end else if (cmp_ev) begin
        if (mode == ecmd_pkg::M_CMP_TGL) cmp_out_q <= ~cmp_out_q;
        if (mode == ecmd_pkg::M_CMP_SET) cmp_out_q <= 1'b1;
        if (mode == ecmd_pkg::M_CMP_CLR) cmp_out_q <= 1'b0;
      end
    end
  end

  // special event trigger pulses
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_reset_q <= 1'b0;
      adc_start_q <= 1'b0;
    end else begin
      tmr_reset_q <= cmp_ev & (mode == ecmd_pkg::M_CMP_TRIG);
      adc_start_q <= cmp_ev & (mode == ecmd_pkg::M_CMP_TRIG);
    end
  end

  // interrupt flag, set wins over a write-one clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= (flag_q & ~(wr & (paddr == ecmd_pkg::OFS_STAT) &
        pwdata[ecmd_pkg::STAT_FLAG_BIT])) | cap_ev | cmp_ev;
    end
  end

  // pwm arming and duty shadow
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      duty_sh_q <= 10'h0;
    end else begin
      if (!is_pwm(mode)) begin
        run_q <= 1'b0;
      end else if (pwm_period_start) begin
        run_q <= 1'b1;
        duty_sh_q <= {duty_hi_q, ctrl_q.duty_low_bits};
      end
    end
  end

  assign raw = run_q & (pwm_count < duty_sh_q);

  // dead band on each edge of the modulated signal
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      raw_prev_q <= 1'b0;
      db_cnt_q <= 7'h0;
    end else begin
      raw_prev_q <= raw;
      if (!is_pwm(mode)) begin
        db_cnt_q <= 7'h0;
      end else if (raw != raw_prev_q) begin
        db_cnt_q <= dband_q;
      end else if (db_cnt_q != 7'h0) begin
        db_cnt_q <= db_cnt_q - 7'h1;
      end
    end
  end

  assign db_idle = (raw == raw_prev_q) && (db_cnt_q == 7'h0);

  // output configuration decode
  always_comb begin
    act = 4'h0;
    oe_n = 4'hf;
    if (!is_pwm(mode)) begin
      unique case (mode)
        ecmd_pkg::M_CMP_TGL, ecmd_pkg::M_CMP_SET, ecmd_pkg::M_CMP_CLR:
          begin
          act = {3'h0, cmp_out_q};
          oe_n = 4'b1110;
        end
        default: begin
          act = 4'h0;
          oe_n = 4'hf;
        end
      endcase
    end else begin
      unique case (ctrl_q.output_configuration_field)
        ecmd_pkg::CFG_SINGLE: begin
          act = steer_q & {4{raw}};
          oe_n = ~steer_q;
        end
        ecmd_pkg::CFG_FWD: begin
          act = {raw, 2'b00, run_q};
          oe_n = 4'h0;
        end
        ecmd_pkg::CFG_HALF: begin
          act = {2'b00, ~raw & db_idle, raw & db_idle};
          oe_n = 4'b1100;
        end
        ecmd_pkg::CFG_REV: begin
          act = {1'b0, run_q, raw, 1'b0};
          oe_n = 4'h0;
        end
      endcase
    end
  end

  // polarity per output: a and c from mode bit 1, b and d from bit 0
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pol
      assign pol[gi] = is_pwm(mode) & mode[gi % 2 == 0 ? 1 : 0];
      assign drv[gi] = act[gi] ^ pol[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= {4'h0, 4'hf};
    end else begin
      pin_q <= {drv, oe_n};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  flag_set_a: assert property (cap_ev |=> flag_q)
    else $error("flag not set by capture");
  capt_val_a: assert property (cap_ev |=> capt_q == $past(tmr_value))
    else $error("captured value wrong");
  presc16_a: assert property (mode == ecmd_pkg::M_CAP_16 && cap_ev
    |-> presc_q == 4'hf)
    else $error("16th edge capture early");
  off_clear_a: assert property (mode == ecmd_pkg::M_OFF &&
    !(wr && paddr == ecmd_pkg::OFS_CTRL)
    |=> presc_q == 4'h0 && !run_q && !cmp_out_q)
    else $error("off mode left state");
  toggle_a: assert property (cmp_ev && mode == ecmd_pkg::M_CMP_TGL
    && !wr |=> cmp_out_q != $past(cmp_out_q))
    else $error("compare toggle missing");
  set_high_a: assert property (cmp_ev && mode == ecmd_pkg::M_CMP_SET
    && !wr |=> ##1 pin_q.drv[0] && !pin_q.oe_n[0])
    else $error("compare pin not set");
  clr_low_a: assert property (cmp_ev && mode == ecmd_pkg::M_CMP_CLR
    && !wr |=> flag_q ##1 !pin_q.drv[0])
    else $error("compare pin not cleared");
  swi_a: assert property (mode == ecmd_pkg::M_CMP_SWI
    |=> pin_q.oe_n == 4'hf)
    else $error("pin driven in software interrupt mode");
  trig_a: assert property (cmp_ev && mode == ecmd_pkg::M_CMP_TRIG
    |=> tmr_reset_q && adc_start_q ##1 !tmr_reset_q)
    else $error("special event trigger wrong");
  port_pins_a: assert property (!is_pwm(mode)
    |=> pin_q.oe_n[3:1] == 3'b111)
    else $error("port pins driven outside pwm");
  fwd_a: assert property (run_q && mode == ecmd_pkg::M_PWM_HH &&
    ctrl_q.output_configuration_field == ecmd_pkg::CFG_FWD
    |=> pin_q.drv[2:0] == 3'b001)
    else $error("forward bridge levels wrong");
  rev_a: assert property (run_q && mode == ecmd_pkg::M_PWM_LL &&
    ctrl_q.output_configuration_field == ecmd_pkg::CFG_REV
    |=> pin_q.drv[3] && !pin_q.drv[2] && pin_q.drv[0])
    else $error("reverse bridge levels wrong");
  hold_off_a: assert property (is_pwm(mode) && !run_q && !pwm_period_start
    |=> !run_q)
    else $error("pwm started mid period");
  duty_a: assert property (is_pwm(mode) && pwm_period_start
    |=> duty_sh_q == {$past(duty_hi_q), $past(ctrl_q.duty_low_bits)})
    else $error("duty value not assembled");

  cap_c: cover property (mode == ecmd_pkg::M_CAP_4 && cap_ev);
  trig_c: cover property (cmp_ev && mode == ecmd_pkg::M_CMP_TRIG);
  half_c: cover property (run_q &&
    ctrl_q.output_configuration_field == ecmd_pkg::CFG_HALF &&
    db_cnt_q != 7'h0);

endmodule // ecmd_top

// ### bench/ecmd_far_model.sv
`timescale 1ns/1ps
module ecmd_far_model #(
  parameter int PERIOD = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // timer control
  input wire logic tmr_reset,
  input wire logic tmr_clr,
  // timebases
  output logic [15:0] tmr_value,
  output logic [9:0] pwm_count,
  output logic pwm_period_start
);
  // timer restarts from zero on a special event
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_value <= 16'h0000;
    end else if (tmr_reset || tmr_clr) begin
      tmr_value <= 16'h0000;
    end else begin
      tmr_value <= tmr_value + 16'h0001;
    end
  end
  // free running pwm period
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_count <= 10'h000;
    end else if (pwm_count == 10'(PERIOD - 1)) begin
      pwm_count <= 10'h000;
    end else begin
      pwm_count <= pwm_count + 10'h001;
    end
  end
  assign pwm_period_start = (pwm_count == 10'h000);
endmodule // ecmd_far_model

// ### bench/enhanced_ccp_mode_decode_tb.sv
`timescale 1ns/1ps
module enhanced_ccp_mode_decode_tb;
  logic ref_clk, nrst, psel, penable, pwrite, cap_pin_in, tmr_clr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, tmr_reset, adc_start, unit_interrupt_flag;
  logic [15:0] tmr_value;
  logic [9:0] pwm_count;
  logic pwm_period_start;
  ecmd_pkg::ecmd_pins_t pin_q;
  int num_errors, check_count, trig_n;

  ecmd_top ecmd_top_i (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr_value(tmr_value), .pwm_count(pwm_count),
    .pwm_period_start(pwm_period_start), .cap_pin_in(cap_pin_in),
    .pin_q(pin_q), .tmr_reset(tmr_reset), .adc_start(adc_start),
    .unit_interrupt_flag(unit_interrupt_flag));
  ecmd_far_model ecmd_far_model_i (.ref_clk(ref_clk), .nrst(nrst),
    .tmr_reset(tmr_reset), .tmr_clr(tmr_clr), .tmr_value(tmr_value),
    .pwm_count(pwm_count), .pwm_period_start(pwm_period_start));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (tmr_reset === 1'b1 && adc_start === 1'b1) trig_n++;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_test();
    apb(1'b0, ecmd_pkg::OFS_STEER, 32'h0);
    chk(rd, 32'(ecmd_pkg::STEER_RST));
    apb(1'b0, ecmd_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ecmd_pkg::OFS_CTRL, 32'hffff_ffa5);
    apb(1'b0, ecmd_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'ha5);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, ecmd_pkg::OFS_DUTY_HI, 32'h20);
  endtask

  task automatic cmp_test(input logic [3:0] m, input logic i0,
      input logic i1, input logic [3:0] oe);
    int t0;
    int n;
    tmr_clr <= 1'b1;
    @(posedge ref_clk);
    tmr_clr <= 1'b0;
    apb(1'b1, ecmd_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, ecmd_pkg::OFS_STAT, 32'h1);
    chk(32'(pin_q.oe_n), 32'hf);
    apb(1'b1, ecmd_pkg::OFS_CTRL, {24'h0, 4'hf, m});
    t0 = trig_n;
    repeat (3) @(posedge ref_clk);
    chk(32'(pin_q.oe_n), 32'(oe));
    if (!oe[0]) chk(32'(pin_q.drv[0]), 32'(i0));
    n = 0;
    while (unit_interrupt_flag !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(unit_interrupt_flag), 32'h1);
    repeat (3) @(posedge ref_clk);
    if (!oe[0]) chk(32'(pin_q.drv[0]), 32'(i1));
    chk(32'(trig_n - t0), (m == 4'hb) ? 32'h1 : 32'h0);
  endtask

  task automatic cap_test(input logic [3:0] m, input int k,
      input logic fall);
    logic [15:0] t;
    apb(1'b1, ecmd_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, ecmd_pkg::OFS_CTRL, {28'h0, m});
    apb(1'b1, ecmd_pkg::OFS_STAT, 32'h1);
    for (int i = 1; i <= k; i++) begin
      cap_pin_in <= 1'b1;
      @(posedge ref_clk);
      if (!fall) t = tmr_value;
      cap_pin_in <= 1'b0;
      @(posedge ref_clk);
      if (fall) t = tmr_value;
      repeat (3) @(posedge ref_clk);
      chk(32'(unit_interrupt_flag), 32'(i == k));
    end
    apb(1'b0, ecmd_pkg::OFS_CAPT, 32'h0);
    chk(rd, 32'(t));
  endtask

  task automatic rsv_test(input logic [3:0] m);
    apb(1'b1, ecmd_pkg::OFS_CTRL, {28'h0, m});
    apb(1'b1, ecmd_pkg::OFS_STAT, 32'h1);
    tmr_clr <= 1'b1;
    cap_pin_in <= 1'b1;
    @(posedge ref_clk);
    tmr_clr <= 1'b0;
    repeat (40) @(posedge ref_clk);
    cap_pin_in <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk(32'(unit_interrupt_flag), 32'h0);
    chk(32'(pin_q.oe_n), 32'hf);
  endtask

  task automatic pwm_test(input logic [7:0] c, input logic [3:0] e,
      input logic [3:0] oe);
    apb(1'b1, ecmd_pkg::OFS_CTRL, {24'h0, c});
    repeat (40) @(posedge ref_clk);
    chk(32'(pin_q.oe_n), 32'(oe));
    chk(32'(pin_q.drv & ~pin_q.oe_n), 32'(e & ~oe));
  endtask

  task automatic duty_test();
    int hi;
    hi = 0;
    apb(1'b1, ecmd_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, ecmd_pkg::OFS_DUTY_HI, 32'h2);
    apb(1'b1, ecmd_pkg::OFS_CTRL, 32'h1c);
    while (pwm_period_start !== 1'b1) begin
      chk(32'(pin_q.drv[0]), 32'h0);
      @(posedge ref_clk);
    end
    repeat (40) @(posedge ref_clk);
    repeat (16) begin
      @(posedge ref_clk);
      hi += int'(pin_q.drv[0]);
    end
    chk(32'(hi), 32'h9);
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cap_pin_in = 1'b0;
    tmr_clr = 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(32'(pin_q.oe_n), 32'hf);
    reg_test();
    cmp_test(4'h8, 1'b0, 1'b1, 4'he);
    cmp_test(4'h9, 1'b1, 1'b0, 4'he);
    cmp_test(4'h2, 1'b0, 1'b1, 4'he);
    cmp_test(4'ha, 1'b0, 1'b0, 4'hf);
    cmp_test(4'hb, 1'b0, 1'b0, 4'hf);
    cap_test(4'h4, 1, 1'b1);
    cap_test(4'h5, 1, 1'b0);
    cap_test(4'h6, 4, 1'b0);
    cap_test(4'h7, 16, 1'b0);
    rsv_test(4'h1);
    rsv_test(4'h3);
    apb(1'b1, ecmd_pkg::OFS_DUTY_HI, 32'h0);
    pwm_test(8'h4c, 4'h1, 4'h0);
    pwm_test(8'h4f, 4'he, 4'h0);
    pwm_test(8'hcd, 4'he, 4'h0);
    pwm_test(8'hcc, 4'h4, 4'h0);
    pwm_test(8'hcf, 4'hb, 4'h0);
    pwm_test(8'h8c, 4'h2, 4'hc);
    pwm_test(8'h8e, 4'h3, 4'hc);
    pwm_test(8'h0c, 4'h0, 4'he);
    duty_test();
    end_of_test();
  end
endmodule // enhanced_ccp_mode_decode_tb
